// [design/fbm_pkg.sv]
package fbm_pkg;

  // ---------------------------------------------------------------
  // mode pin codes, in the order hi:mid:lo
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_SERIAL_PROM = 3'h0;
  localparam logic [2:0] MODE_SPI_FLASH   = 3'h6;
  localparam logic [2:0] MODE_PAR_UP      = 3'h2;
  localparam logic [2:0] MODE_PAR_DOWN    = 3'h3;

  // ---------------------------------------------------------------
  // address space and clocks
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 25;
  localparam logic [24:0] PAR_TOP_ADDR = 25'h1ffffff;
  localparam logic [24:0] ZERO_ADDR    = 25'h0000000;
  localparam int         CORE_CLK_KHZ  = 125000;
  localparam int         CFG_CLK_KHZ   = 1500;
  // longest half period of the slow config clock, rounded down
  localparam int         SLOW_HALF_CYC = CORE_CLK_KHZ / (2 * CFG_CLK_KHZ);
  localparam logic [7:0] SLOW_DIV_RST  = 8'(SLOW_HALF_CYC - 1);
  localparam int         DEB_CYC       = 4096;
  localparam int         FIFO_W        = 8;
  localparam int         FIFO_D        = 32;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_IMAGE1 = 8'h0c;
  localparam logic [7:0] REG_COUNT  = 8'h10;
  localparam logic [7:0] REG_DATA   = 8'h14;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [24:0] IMAGE1_RST = 25'h1000000;
  localparam logic [23:0] COUNT_RST  = 24'h000100;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_LOAD   = 3'b010,
    ST_DONE   = 3'b011,
    ST_FAIL   = 3'b100
  } fbm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              down;
    logic [2:0]        mode;
  } fbm_src_t;

endpackage

// [design/fbm_mem.sv]
`timescale 1ns/1ps
module fbm_mem
  import fbm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock
  input  wire logic             core_clk,
  // write side
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read side
  input  wire logic             rdEn,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem_ff[wrAddr] <= wrData;
    end
  end

  // read word is held until the next pop, so a push cannot disturb it
  always_ff @(posedge core_clk) begin
    if (rdEn) begin
      rdData <= mem_ff[rdAddr];
    end
  end
endmodule

// [design/fbm_fifo.sv]
`timescale 1ns/1ps
module fbm_fifo
  import fbm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  logic [AW:0]      count;
  logic             pushEn;
  logic             popEn;
  logic [WIDTH-1:0] memRd;
  logic             shown_ff;

  // read data lags the pointer one cycle, so a one-word view is kept
  assign count    = wrPtr_ff - rdPtr_ff;
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign pushEn   = inValid && inReady;
  assign outValid = shown_ff;
  assign outData  = memRd;
  assign popEn    = (count != '0) && (!shown_ff || outReady);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_ff <= '0;
    end else if (pushEn) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdPtr_ff <= '0;
      shown_ff <= 1'b0;
    end else begin
      if (popEn) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (popEn) begin
        shown_ff <= 1'b1;
      end else if (outReady) begin
        shown_ff <= 1'b0;
      end
    end
  end

  fbm_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) mem (
    .core_clk (core_clk),
    .wrEn     (pushEn),
    .wrAddr   (wrPtr_ff[AW-1:0]),
    .wrData   (inData),
    .rdEn     (popEn),
    .rdAddr   (rdPtr_ff[AW-1:0]),
    .rdData   (memRd)
  );
endmodule

// [design/fbm_boot_select.sv]
`timescale 1ns/1ps
module fbm_boot_select
  import fbm_pkg::*;
#(
  parameter int DEB_COUNT = DEB_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // board pins
  input  wire logic        modeSelectHi,
  input  wire logic        modeSelectMid,
  input  wire logic        modeSelectLo,
  input  wire logic        restartBtn,
  input  wire logic        imageDataIn,
  output logic             configClock,
  output logic             parAddrOe,
  output logic [19:0]      parAddrLow,
  output logic             configDone,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  default clocking chkClk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  // no reset: the pins must be settled when reset lets go
  always_ff @(posedge core_clk) begin
    sync1_ff <= {modeSelectHi, modeSelectMid, modeSelectLo,
                 restartBtn, imageDataIn};
    sync2_ff <= sync1_ff;
  end
  logic [2:0] modePins;
  logic       btnSync;
  logic       dataSync;
  // open pin reads one, jumper pulls zero
  assign modePins = sync2_ff[4:2];
  assign btnSync  = sync2_ff[1];
  assign dataSync = sync2_ff[0];

  // ---------------------------------------------------------------
  // button debounce
  // ---------------------------------------------------------------
  logic        btnStable_ff;
  logic [15:0] debCnt_ff;
  logic        btnPress_ff;
  // a press counts only after the level holds steady
  always_ff @(posedge core_clk) begin
    if (reset) begin
      btnStable_ff <= 1'b0;
      debCnt_ff    <= '0;
      btnPress_ff  <= 1'b0;
    end else begin
      btnPress_ff <= 1'b0;
      if (btnSync == btnStable_ff) begin
        debCnt_ff <= '0;
      end else if (debCnt_ff == 16'(DEB_COUNT - 1)) begin
        debCnt_ff    <= '0;
        btnStable_ff <= btnSync;
        btnPress_ff  <= btnSync;
      end else begin
        debCnt_ff <= debCnt_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_ff;
  logic [24:0] image1_ff;
  logic [23:0] loadLen_ff;
  logic        reloadReq_ff;
  logic        apbWr;
  logic        apbRd;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;

  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ADDR) ||
             (a == REG_IMAGE1) || (a == REG_COUNT) || (a == REG_DATA);
  endfunction

  // ctrl: bit0 image select, bit1 reload strobe, bits 3:2 clock rate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff      <= CTRL_RST;
      image1_ff    <= IMAGE1_RST;
      loadLen_ff   <= COUNT_RST;
      reloadReq_ff <= 1'b0;
    end else begin
      reloadReq_ff <= 1'b0;
      if (apbWr && paddr == REG_CTRL) begin
        ctrl_ff      <= {pwdata[7:2], 1'b0, pwdata[0]};
        reloadReq_ff <= pwdata[1];
      end
      if (apbWr && paddr == REG_IMAGE1) begin
        image1_ff <= pwdata[24:0];
      end
      if (apbWr && paddr == REG_COUNT) begin
        loadLen_ff <= pwdata[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration clock divider
  // ---------------------------------------------------------------
  logic [7:0] divCnt_ff;
  logic [7:0] divLoad;
  logic       cfgTick;
  logic [1:0] rateSel_ff;
  // slowest rate until the first sampled bit loads ctrl bits 3:2
  assign divLoad = SLOW_DIV_RST >> rateSel_ff;
  assign cfgTick = (divCnt_ff == 8'h00);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      divCnt_ff <= SLOW_DIV_RST;
    end else if (cfgTick) begin
      divCnt_ff <= divLoad;
    end else begin
      divCnt_ff <= divCnt_ff - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  fbm_state_t state_ff;
  fbm_src_t   src_ff;
  logic       imageSel_ff;
  logic [23:0] bitCnt_ff;
  logic        clkPhase_ff;
  logic        done_ff;
  logic [7:0]  shift_ff;
  logic [2:0]  shCnt_ff;
  logic        fifoInValid;
  logic        fifoInReady;
  logic        restart;
  logic        sampleEdge;
  assign restart = btnPress_ff || reloadReq_ff;
  assign sampleEdge = cfgTick && clkPhase_ff && (state_ff == ST_LOAD) &&
                      fifoInReady;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff    <= ST_SAMPLE;
      imageSel_ff <= 1'b0;
    end else if (restart) begin
      // abandon whatever is in flight
      state_ff <= ST_SAMPLE;
      if (reloadReq_ff) begin
        imageSel_ff <= ctrl_ff[0];
      end
    end else begin
      case (state_ff)
        ST_IDLE:   state_ff <= ST_IDLE;
        ST_SAMPLE: begin
          case (modePins)
            MODE_SERIAL_PROM, MODE_SPI_FLASH,
            MODE_PAR_UP, MODE_PAR_DOWN: state_ff <= ST_LOAD;
            default: state_ff <= ST_FAIL;
          endcase
        end
        ST_LOAD: begin
          if (sampleEdge && bitCnt_ff == 24'h000001) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE:   state_ff <= ST_DONE;
        ST_FAIL:   state_ff <= ST_FAIL;
        default:   state_ff <= ST_IDLE;
      endcase
    end
  end

  // mode and image source taken on each sample
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_ff     <= '0;
      rateSel_ff <= 2'h0;
    end else if (state_ff == ST_SAMPLE && !restart) begin
      src_ff.mode <= modePins;
      rateSel_ff  <= 2'h0;
      src_ff.down <= (modePins == MODE_PAR_DOWN);
      case (modePins)
        MODE_PAR_UP: begin
          src_ff.addr <= imageSel_ff ? image1_ff : ZERO_ADDR;
        end
        MODE_PAR_DOWN: begin
          src_ff.addr <= PAR_TOP_ADDR;
        end
        default: begin
          src_ff.addr <= ZERO_ADDR;
        end
      endcase
    end else if (sampleEdge) begin
      rateSel_ff <= ctrl_ff[3:2];
      if (src_ff.mode == MODE_PAR_UP || src_ff.mode == MODE_PAR_DOWN) begin
        src_ff.addr <= src_ff.down ? src_ff.addr - 25'h1
                                   : src_ff.addr + 25'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || restart || state_ff != ST_LOAD) begin
      bitCnt_ff   <= loadLen_ff;
      clkPhase_ff <= 1'b0;
      shCnt_ff    <= 3'h0;
      shift_ff    <= 8'h00;
    end else if (cfgTick && (fifoInReady || !clkPhase_ff)) begin
      clkPhase_ff <= !clkPhase_ff;
      if (clkPhase_ff) begin
        bitCnt_ff <= bitCnt_ff - 24'h000001;
        shift_ff  <= {shift_ff[6:0], dataSync};
        shCnt_ff  <= shCnt_ff + 3'h1;
      end
    end
  end
  assign fifoInValid = sampleEdge && (shCnt_ff == 3'h7);

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      configClock <= 1'b0;
      parAddrOe   <= 1'b0;
      parAddrLow  <= 20'h00000;
      done_ff     <= 1'b0;
    end else begin
      configClock <= (state_ff == ST_LOAD) && clkPhase_ff;
      // upper lines 24..20 are left to the helper logic
      parAddrOe   <= (state_ff == ST_LOAD) &&
                     (src_ff.mode == MODE_PAR_UP ||
                      src_ff.mode == MODE_PAR_DOWN);
      parAddrLow  <= src_ff.addr[19:0];
      done_ff     <= (state_ff == ST_DONE) && !restart;
    end
  end
  assign configDone = done_ff;

  // ---------------------------------------------------------------
  // captured data fifo
  // ---------------------------------------------------------------
  logic       fifoOutValid;
  logic [7:0] fifoOutData;
  logic       fifoPop;
  // pop only the byte this read reported, never one shown since setup
  assign fifoPop = apbRd && paddr == REG_DATA && prdata[8] && fifoOutValid;

  fbm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) fifo (
    .core_clk (core_clk),
    .reset    (reset || restart),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   ({shift_ff[6:0], dataSync}),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    case (paddr)
      REG_CTRL:   rdMux = {24'h000000, ctrl_ff};
      REG_STATUS: rdMux = {24'h000000, imageSel_ff, src_ff.mode,
                           fifoOutValid, state_ff[2:0]};
      REG_ADDR:   rdMux = {7'h00, src_ff.addr};
      REG_IMAGE1: rdMux = {7'h00, image1_ff};
      REG_COUNT:  rdMux = {8'h00, bitCnt_ff};
      REG_DATA:   rdMux = {23'h000000, fifoOutValid, fifoOutData};
      default:    rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !regHit(paddr);
      prdata  <= (psel && !penable) ? rdMux : prdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  done_needs_load_a: assert property (
    $rose(configDone) |-> $past(state_ff, 2) == ST_LOAD)
    else $error("done rose without a load");
  restart_drops_a: assert property (
    restart |=> state_ff == ST_SAMPLE ##1 !configDone)
    else $error("restart did not abandon state");
  down_start_a: assert property (
    state_ff == ST_SAMPLE && !restart && modePins == MODE_PAR_DOWN
    |=> src_ff.addr == PAR_TOP_ADDR)
    else $error("downward load not at top");
  up_start_a: assert property (
    state_ff == ST_SAMPLE && !restart && modePins == MODE_PAR_UP &&
    !imageSel_ff |=> src_ff.addr == ZERO_ADDR)
    else $error("upward load not at zero");
  mode_taken_a: assert property (
    state_ff == ST_SAMPLE && !restart |=> src_ff.mode == $past(modePins))
    else $error("mode not sampled");
  spi_zero_a: assert property (
    state_ff == ST_SAMPLE && !restart && modePins == MODE_SPI_FLASH
    |=> src_ff.addr == ZERO_ADDR)
    else $error("spi load not at zero");
  serial_load_a: assert property (
    state_ff == ST_SAMPLE && !restart && modePins == MODE_SERIAL_PROM
    |=> state_ff == ST_LOAD || restart)
    else $error("serial mode did not load");
  slow_start_a: assert property (
    state_ff == ST_SAMPLE |=> rateSel_ff == 2'h0)
    else $error("config clock not slowest");
  single_press_a: assert property (
    btnPress_ff |=> !btnPress_ff [*2])
    else $error("button pressed twice");
  image_pick_a: assert property (
    reloadReq_ff |=> imageSel_ff == $past(ctrl_ff[0]))
    else $error("reload image not taken");
endmodule

// [bench/fbm_image_prom.sv]
`timescale 1ns/1ps
module fbm_image_prom (
  // image clock and restart of the stream
  input  wire logic configClock,
  input  wire logic rewind,
  // serial data to the loader
  output logic      imageDataIn
);
  // ---------------------------------------------------------------
  // bit source
  // ---------------------------------------------------------------
  // a byte pattern that differs every byte, so a slip shows at once
  // no jtag download here; its clock swap is the host's job
  int         bitIdx = 0;
  logic [7:0] curByte;

  // upper flash address lines belong to the helper logic
  always @(negedge configClock or posedge rewind) begin
    if (rewind) begin
      bitIdx <= 0;
    end else begin
      bitIdx <= bitIdx + 1;
    end
  end

  // new bit on the falling edge, steady for the loader's rising edge
  assign curByte     = 8'((bitIdx / 8) * 7 + 3);
  assign imageDataIn = curByte[3'(7 - bitIdx % 8)];
endmodule

// [bench/fbm_boot_select_test.sv]
`timescale 1ns/1ps
module fbm_boot_select_test;
  import fbm_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct {
    logic [2:0]  mode;
    logic        oe;
    logic [19:0] addr;
    logic [2:0]  st;
  } fbm_row_t;

  logic        core_clk      = 1'b0;
  logic        reset         = 1'b1;
  logic        modeSelectHi  = 1'b1;
  logic        modeSelectMid = 1'b1;
  logic        modeSelectLo  = 1'b1;
  logic        restartBtn    = 1'b0;
  logic        rewind        = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [7:0]  paddr         = 8'h00;
  logic [31:0] pwdata        = 32'h0;
  logic        imageDataIn;
  logic        configClock;
  logic        parAddrOe;
  logic [19:0] parAddrLow;
  logic        configDone;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] d;
  logic        e;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          k;
  int          q;
  logic        lastClk;
  fbm_row_t    rows [5];

  fbm_boot_select #(.DEB_COUNT(4)) dut (
    .core_clk(core_clk), .reset(reset), .modeSelectHi(modeSelectHi),
    .modeSelectMid(modeSelectMid), .modeSelectLo(modeSelectLo),
    .restartBtn(restartBtn), .imageDataIn(imageDataIn),
    .configClock(configClock), .parAddrOe(parAddrOe),
    .parAddrLow(parAddrLow), .configDone(configDone), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  fbm_image_prom prom (
    .configClock(configClock), .rewind(rewind),
    .imageDataIn(imageDataIn));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; waits an edge first so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // hold the prom at bit zero until the old config clock has fallen
  task automatic rewindProm();
    rewind <= 1'b1;
    repeat (4) @(posedge core_clk);
    rewind <= 1'b0;
  endtask

  task automatic boot(input logic [2:0] m, input logic [31:0] bits);
    logic [31:0] r;
    logic        x;
    {modeSelectHi, modeSelectMid, modeSelectLo} <= m;
    reset <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({29'h0, configDone, parAddrOe, pready}, 32'h0);
    reset <= 1'b0;
    apb(1'b1, REG_COUNT, bits, r, x);
    // reload at the fastest clock keeps the run short
    apb(1'b1, REG_CTRL, 32'h0000000e, r, x);
    rewindProm();
  endtask

  task automatic firstRise(input logic oe, input logic [19:0] a);
    int n;
    n = 0;
    while (configClock !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, parAddrOe}, {31'h0, oe});
    check({12'h0, parAddrLow}, {12'h0, a});
    check({31'h0, configDone}, 32'h0);
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (configDone !== 1'b1 && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, configDone}, 32'h1);
  endtask

  task automatic drain(input int cnt);
    logic [31:0] r;
    logic        x;
    int          n;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      r = 32'h0;
      while (r[8] !== 1'b1 && n < 500) begin
        apb(1'b0, REG_DATA, 32'h0, r, x);
        n++;
      end
      check(r & 32'h1ff, {23'h0, 1'b1, 8'(i * 7 + 3)});
    end
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = '{MODE_SERIAL_PROM, 1'b0, 20'h0, 3'h3};
    rows[1] = '{MODE_SPI_FLASH, 1'b0, 20'h0, 3'h3};
    rows[2] = '{MODE_PAR_UP, 1'b1, 20'h0, 3'h3};
    rows[3] = '{MODE_PAR_DOWN, 1'b1, PAR_TOP_ADDR[19:0], 3'h3};
    rows[4] = '{3'h7, 1'b0, 20'h0, 3'h4};
    for (int i = 0; i < 5; i++) begin
      boot(rows[i].mode, 32'd16);
      if (rows[i].st == 3'h3) begin
        firstRise(rows[i].oe, rows[i].addr);
        waitDone();
      end else begin
        repeat (100) @(posedge core_clk);
      end
      apb(1'b0, REG_STATUS, 32'h0, d, e);
      check(d & 32'h77, {25'h0, rows[i].mode, 1'b0, rows[i].st});
      check({31'h0, configDone}, {31'h0, rows[i].st == 3'h3});
      if (rows[i].st == 3'h3) begin
        drain(2);
      end
    end

    // unmapped address answers with an error and no data
    apb(1'b0, 8'h40, 32'h0, d, e);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);

    // bounce shorter than the debounce span must not restart
    boot(MODE_PAR_UP, 32'd16);
    waitDone();
    restartBtn <= 1'b1;
    repeat (2) @(posedge core_clk);
    restartBtn <= 1'b0;
    repeat (30) @(posedge core_clk);
    check({31'h0, configDone}, 32'h1);
    // real press after a pin change: restart with the new source
    {modeSelectHi, modeSelectMid, modeSelectLo} <= MODE_PAR_DOWN;
    restartBtn <= 1'b1;
    repeat (12) @(posedge core_clk);
    restartBtn <= 1'b0;
    repeat (20) @(posedge core_clk);
    check({31'h0, configDone}, 32'h0);
    rewindProm();
    firstRise(1'b1, PAR_TOP_ADDR[19:0]);
    waitDone();
    drain(2);

    // reload into the second image, upward from its base
    boot(MODE_PAR_UP, 32'd16);
    apb(1'b1, REG_IMAGE1, 32'h00123450, d, e);
    apb(1'b1, REG_CTRL, 32'h0000000f, d, e);
    rewindProm();
    firstRise(1'b1, 20'h23450);
    waitDone();
    apb(1'b0, REG_STATUS, 32'h0, d, e);
    check(d & 32'hf7, 32'h000000a3);
    apb(1'b0, REG_ADDR, 32'h0, d, e);
    check(d, 32'h00123460);

    // more bytes than the buffer holds: clock must stall, then resume
    boot(MODE_PAR_UP, 32'd320);
    k = 0;
    q = 0;
    lastClk = configClock;
    while (q < 150 && k < 8000) begin
      @(posedge core_clk);
      q = (configClock !== lastClk) ? 0 : q + 1;
      lastClk = configClock;
      k++;
    end
    apb(1'b0, REG_STATUS, 32'h0, d, e);
    check(d & 32'h0f, 32'h0000000a);
    check({31'h0, configDone}, 32'h0);
    drain(40);
    waitDone();
    results();
  end
endmodule
